// [hw/pll_b_cfg_consts.svh]
// Offsets, field positions, reset values and masks of the PLL-B bank.
// Assumes a byte-wide register port with 16-bit addresses.
`ifndef PLL_B_CFG_CONSTS_SVH
`define PLL_B_CFG_CONSTS_SVH

`define REG_COUNT 9
`define OFS_PUMP_FILTER 16'h00B0
`define OFS_LOCK_MODE 16'h00B1
`define OFS_VCO1_MANUAL 16'h00B2
`define OFS_VCO2_MANUAL 16'h00B3
`define OFS_PD_RESERVED 16'h00B4
`define OFS_INPUT_REF_DIS 16'h00B5
`define OFS_ANALOG_PLL_DIS 16'h00B6
`define OFS_OUTPUT_DIS 16'h00B7
`define OFS_DPLL_CAL 16'h00B8

// Field positions (lsb) inside each byte
`define POS_PUMP_CURRENT 5
`define POS_SERIES_RES 3
`define POS_PARALLEL_CAP 1
`define POS_SECOND_POLE 0
`define POS_SYNTH_ONLY 3
`define POS_LOCK_COUNT 1
`define POS_LOCK_OVERRIDE 0
`define POS_VCO_CHOICE 5
`define POS_LOCK_VALUE 0
`define POS_XTAL_DBL_OFF 0
`define POS_INPUT_REF_OFF 0
`define POS_ANALOG_PLL_OFF 1
`define POS_OUTPUT_OFF 0
`define POS_CAL_HOLD 0
`define POS_DPLL_OFF 2

// Reset values
`define RST_PUMP_FILTER 8'h8B
`define RST_LOCK_MODE 8'h02
`define RST_VCO1_MANUAL 8'h2B
`define RST_VCO2_MANUAL 8'h00
`define RST_PD_RESERVED 8'h00
`define RST_INPUT_REF_DIS 8'h00
`define RST_ANALOG_PLL_DIS 8'h00
`define RST_OUTPUT_DIS 8'h00
`define RST_DPLL_CAL 8'h00

// Implemented bits; the rest are reserved and read as zero
`define MSK_PUMP_FILTER 8'hFF
`define MSK_LOCK_MODE 8'h0B
`define MSK_VCO1_MANUAL 8'h3F
`define MSK_VCO2_MANUAL 8'h1F
`define MSK_PD_RESERVED 8'h01
`define MSK_INPUT_REF_DIS 8'h0F
`define MSK_ANALOG_PLL_DIS 8'h02
`define MSK_OUTPUT_DIS 8'hFF
`define MSK_DPLL_CAL 8'h0F

`endif

// [hw/pll_b_cfg_pkg.sv]
// Types shared by the PLL-B configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package pll_b_cfg_pkg;
  typedef logic [15:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef logic [2:0] pump_current_t;
  typedef logic [1:0] filter_sel_t;
  typedef logic [4:0] lock_value_t;
  typedef enum logic {
    LOCK_AUTO = 1'b0,
    LOCK_MANUAL = 1'b1
  } lock_mode_t;
  typedef enum logic {
    VCO_SECOND = 1'b0,
    VCO_FIRST = 1'b1
  } vco_choice_t;
endpackage : pll_b_cfg_pkg

// [hw/cfg_byte_reg.sv]
// One byte-wide configuration register with a reset value and bit mask.
// Assumes a write strobe already decoded for this register.
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] BIT_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wr,
  input wire logic [7:0] wdata,
  // Stored value
  output logic [7:0] q
);
  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  // Reserved positions never store, so they read back as zero
  always_comb begin
    nxt_q = q_ff;
    if (wr) begin
      nxt_q = wdata & BIT_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= RESET_VAL & BIT_MASK;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule : cfg_byte_reg

// [hw/pll_b_cfg_regs.sv]
// PLL-B control and power-down configuration register bank.
// Assumes the serial port logic presents decoded byte reads and writes.
//
// Behaviour
// - Pump current, 3 bits, resets to 100
// - Series resistor select, 2 bits, resets 01
// - Parallel capacitor select, 2 bits, resets 01
// - Second pole select resets to larger resistor
// - Lock count accuracy bit resets to 16 ppm
// - Lock override resets to automatic, 1 manual
// - Manual VCO choice: 1 first, resets 1
// - First VCO manual value resets 01011
// - Second VCO manual value resets 00000
// - Synth-only mode bit resets to translate mode
// - Reserved bits written zero, read as zero
// - Crystal doubler off bit resets to doubled
// - Four input reference off bits reset enabled
// - Analog PLL off bit resets enabled
// - Eight output off bits, set means high-Z
// - Two digital PLL off bits reset enabled
// - Two calibration hold bits reset enabled
`timescale 1ns/1ps
`include "pll_b_cfg_consts.svh"
module pll_b_cfg_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire pll_b_cfg_pkg::reg_addr_t addr,
  input wire pll_b_cfg_pkg::reg_data_t wdata,
  output pll_b_cfg_pkg::reg_data_t rdata,
  output logic rd_valid,
  output logic hit,
  // Analog PLL-B loop settings
  output pll_b_cfg_pkg::pump_current_t pump_current_sel,
  output pll_b_cfg_pkg::filter_sel_t filter_series_res_sel,
  output pll_b_cfg_pkg::filter_sel_t filter_parallel_cap_sel,
  output logic second_pole_sel,
  output logic lock_count_accuracy,
  output pll_b_cfg_pkg::lock_mode_t manual_lock_override,
  output pll_b_cfg_pkg::vco_choice_t manual_vco_choice,
  output pll_b_cfg_pkg::lock_value_t manual_lock_value_first_vco,
  output pll_b_cfg_pkg::lock_value_t manual_lock_value_second_vco,
  output logic synth_only_mode,
  // Lock control actually applied to the analog PLL
  output logic manual_lock_active,
  output pll_b_cfg_pkg::lock_value_t applied_lock_value,
  // Power-down controls
  output logic xtal_doubler_off,
  output logic [3:0] input_ref_off,
  output logic analog_pll_off,
  output logic [7:0] output_off,
  output logic [7:0] output_driver_hiz,
  output logic [1:0] digital_pll_off,
  output logic [1:0] calibration_hold
);
  import pll_b_cfg_pkg::*;

  localparam int NREG = `REG_COUNT;

  logic [3:0] idx;
  logic in_range;
  logic [NREG-1:0] wr_sel;
  logic [7:0] regs [NREG];
  reg_data_t rdata_ff;
  reg_data_t nxt_rdata;
  logic rd_valid_ff;
  logic nxt_rd_valid;

  // Address decode: one item per register offset
  always_comb begin
    in_range = 1'b0;
    idx = 4'h0;
    case (addr)
      `OFS_PUMP_FILTER: begin
        in_range = 1'b1;
        idx = 4'h0;
      end
      `OFS_LOCK_MODE: begin
        in_range = 1'b1;
        idx = 4'h1;
      end
      `OFS_VCO1_MANUAL: begin
        in_range = 1'b1;
        idx = 4'h2;
      end
      `OFS_VCO2_MANUAL: begin
        in_range = 1'b1;
        idx = 4'h3;
      end
      `OFS_PD_RESERVED: begin
        in_range = 1'b1;
        idx = 4'h4;
      end
      `OFS_INPUT_REF_DIS: begin
        in_range = 1'b1;
        idx = 4'h5;
      end
      `OFS_ANALOG_PLL_DIS: begin
        in_range = 1'b1;
        idx = 4'h6;
      end
      `OFS_OUTPUT_DIS: begin
        in_range = 1'b1;
        idx = 4'h7;
      end
      `OFS_DPLL_CAL: begin
        in_range = 1'b1;
        idx = 4'h8;
      end
      default: begin
        in_range = 1'b0;
      end
    endcase
    wr_sel = '0;
    for (int i = 0; i < NREG; i++) begin
      wr_sel[i] = wr_en && in_range && (idx == 4'(i));
    end
  end

  assign hit = in_range;

  // Storage, one register per offset; reserved bits masked off
  // Pump current and loop filter; every bit stored
  cfg_byte_reg #(
    .RESET_VAL(`RST_PUMP_FILTER),
    .BIT_MASK(`MSK_PUMP_FILTER)
  ) u_pump_filter (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[0]),
    .wdata(wdata),
    .q(regs[0])
  );

  // Lock mode; bits 7:4 and 2 are reserved
  cfg_byte_reg #(
    .RESET_VAL(`RST_LOCK_MODE),
    .BIT_MASK(`MSK_LOCK_MODE)
  ) u_lock_mode (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[1]),
    .wdata(wdata),
    .q(regs[1])
  );

  // First VCO value and VCO choice; bits 7:6 reserved
  cfg_byte_reg #(
    .RESET_VAL(`RST_VCO1_MANUAL),
    .BIT_MASK(`MSK_VCO1_MANUAL)
  ) u_vco1_manual (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[2]),
    .wdata(wdata),
    .q(regs[2])
  );

  // Second VCO value; bits 7:5 reserved
  cfg_byte_reg #(
    .RESET_VAL(`RST_VCO2_MANUAL),
    .BIT_MASK(`MSK_VCO2_MANUAL)
  ) u_vco2_manual (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[3]),
    .wdata(wdata),
    .q(regs[3])
  );

  // Crystal doubler; only bit 0 stored
  cfg_byte_reg #(
    .RESET_VAL(`RST_PD_RESERVED),
    .BIT_MASK(`MSK_PD_RESERVED)
  ) u_pd_reserved (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[4]),
    .wdata(wdata),
    .q(regs[4])
  );

  // Input reference disables; upper nibble reserved
  cfg_byte_reg #(
    .RESET_VAL(`RST_INPUT_REF_DIS),
    .BIT_MASK(`MSK_INPUT_REF_DIS)
  ) u_input_ref_dis (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[5]),
    .wdata(wdata),
    .q(regs[5])
  );

  // Analog PLL disable; only bit 1 stored
  cfg_byte_reg #(
    .RESET_VAL(`RST_ANALOG_PLL_DIS),
    .BIT_MASK(`MSK_ANALOG_PLL_DIS)
  ) u_analog_pll_dis (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[6]),
    .wdata(wdata),
    .q(regs[6])
  );

  // Output disables; every bit stored
  cfg_byte_reg #(
    .RESET_VAL(`RST_OUTPUT_DIS),
    .BIT_MASK(`MSK_OUTPUT_DIS)
  ) u_output_dis (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[7]),
    .wdata(wdata),
    .q(regs[7])
  );

  // Digital PLL disables and calibration holds
  cfg_byte_reg #(
    .RESET_VAL(`RST_DPLL_CAL),
    .BIT_MASK(`MSK_DPLL_CAL)
  ) u_dpll_cal (
    .clk(clk),
    .rst(rst),
    .wr(wr_sel[8]),
    .wdata(wdata),
    .q(regs[8])
  );

  // Read path: registered, one cycle after rd_en; unmapped reads zero
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_rd_valid = rd_en;
    if (rd_en) begin
      nxt_rdata = 8'h00;
      if (in_range) begin
        nxt_rdata = regs[idx];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign rdata = rdata_ff;
  assign rd_valid = rd_valid_ff;

  // Loop filter and pump fields
  assign pump_current_sel =
    regs[0][`POS_PUMP_CURRENT +: 3];
  assign filter_series_res_sel =
    regs[0][`POS_SERIES_RES +: 2];
  assign filter_parallel_cap_sel =
    regs[0][`POS_PARALLEL_CAP +: 2];
  assign second_pole_sel = regs[0][`POS_SECOND_POLE];

  // Lock mode fields
  assign lock_count_accuracy = regs[1][`POS_LOCK_COUNT];
  assign manual_lock_override =
    lock_mode_t'(regs[1][`POS_LOCK_OVERRIDE]);
  // Synth mode only steers the loop; the DPLL state lives elsewhere
  assign synth_only_mode = regs[1][`POS_SYNTH_ONLY];
  assign manual_vco_choice =
    vco_choice_t'(regs[2][`POS_VCO_CHOICE]);
  assign manual_lock_value_first_vco =
    regs[2][`POS_LOCK_VALUE +: 5];
  assign manual_lock_value_second_vco =
    regs[3][`POS_LOCK_VALUE +: 5];

  // Manual value only reaches the PLL while override is set
  always_comb begin
    manual_lock_active = (manual_lock_override == LOCK_MANUAL);
    applied_lock_value = 5'h00;
    if (manual_lock_active) begin
      if (manual_vco_choice == VCO_FIRST) begin
        applied_lock_value = manual_lock_value_first_vco;
      end else begin
        applied_lock_value = manual_lock_value_second_vco;
      end
    end
  end

  // Power-down fields
  assign xtal_doubler_off = regs[4][`POS_XTAL_DBL_OFF];
  assign input_ref_off = regs[5][`POS_INPUT_REF_OFF +: 4];
  assign analog_pll_off = regs[6][`POS_ANALOG_PLL_OFF];
  assign output_off = regs[7][`POS_OUTPUT_OFF +: 8];
  assign output_driver_hiz = regs[7][`POS_OUTPUT_OFF +: 8];
  assign digital_pll_off = regs[8][`POS_DPLL_OFF +: 2];
  assign calibration_hold = regs[8][`POS_CAL_HOLD +: 2];
endmodule : pll_b_cfg_regs

// [tb/pll_b_cfg_properties.sv]
// Checker for the PLL-B bank: read timing, field updates, lock select.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module pll_b_cfg_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire pll_b_cfg_pkg::reg_addr_t addr,
  input wire pll_b_cfg_pkg::reg_data_t wdata,
  input wire logic rd_valid,
  // Lock and output controls
  input wire pll_b_cfg_pkg::lock_mode_t manual_lock_override,
  input wire pll_b_cfg_pkg::vco_choice_t manual_vco_choice,
  input wire pll_b_cfg_pkg::lock_value_t manual_lock_value_first_vco,
  input wire pll_b_cfg_pkg::lock_value_t manual_lock_value_second_vco,
  input wire logic manual_lock_active,
  input wire pll_b_cfg_pkg::lock_value_t applied_lock_value,
  input wire logic [7:0] output_off,
  input wire logic [7:0] output_driver_hiz
);
  import pll_b_cfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_read_req; rd_en; endsequence
  sequence s_read_ans; rd_valid; endsequence
  a_read_answer: assert property (s_read_req |=> s_read_ans)
    else $error("read not answered");
  a_read_single: assert property (!rd_en |=> !rd_valid)
    else $error("spurious read valid");
  a_hiz_mirror: assert property (
    output_driver_hiz == output_off) else $error("driver high-z differs");
  a_out_write: assert property (wr_en && addr == 16'h00B7 |=>
    output_off == $past(wdata)) else $error("output write lost");
  a_out_hold: assert property (!wr_en |=> $stable(output_off))
    else $error("output changed unwritten");
  a_first_vco: assert property (
    manual_lock_override == LOCK_MANUAL && manual_vco_choice == VCO_FIRST
    |-> applied_lock_value == manual_lock_value_first_vco)
    else $error("first vco value not applied");
  a_second_vco: assert property (
    manual_lock_override == LOCK_MANUAL && manual_vco_choice == VCO_SECOND
    |-> applied_lock_value == manual_lock_value_second_vco)
    else $error("second vco value not applied");
  a_lock_active: assert property (
    manual_lock_active == (manual_lock_override == LOCK_MANUAL)
    && (manual_lock_active || applied_lock_value == 5'h00))
    else $error("lock mode output wrong");
  a_reset_vals: assert property (
    disable iff (1'b0) rst |->
    manual_lock_value_first_vco == 5'h0B
    && manual_lock_value_second_vco == 5'h00
    && manual_lock_override == LOCK_AUTO && manual_vco_choice == VCO_FIRST)
    else $error("reset value wrong");
endmodule : pll_b_cfg_checker
bind pll_b_cfg_regs pll_b_cfg_checker chk (.clk, .rst, .wr_en, .rd_en, .addr,
  .wdata, .rd_valid, .manual_lock_override, .manual_vco_choice,
  .manual_lock_value_first_vco, .manual_lock_value_second_vco,
  .manual_lock_active, .applied_lock_value, .output_off, .output_driver_hiz);

// [tb/pll_b_cfg_regs_test.sv]
// Self-checking bench for the PLL-B configuration bank.
// Assumes the byte strobe port; inputs change on the falling edge.
`timescale 1ns/1ps
module pll_b_cfg_regs_test;
  import pll_b_cfg_pkg::*;
  logic clk = 1'b1;
  logic rst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  reg_addr_t addr = 16'h0000;
  reg_data_t wdata = 8'h00;
  reg_data_t rdata;
  logic rd_valid, hit, second_pole_sel, lock_count_accuracy, synth_only_mode;
  logic manual_lock_active, xtal_doubler_off, analog_pll_off;
  pump_current_t pump_current_sel;
  filter_sel_t filter_series_res_sel, filter_parallel_cap_sel;
  lock_mode_t manual_lock_override;
  vco_choice_t manual_vco_choice;
  lock_value_t manual_lock_value_first_vco, manual_lock_value_second_vco;
  lock_value_t applied_lock_value;
  logic [3:0] input_ref_off;
  logic [7:0] output_off, output_driver_hiz;
  logic [1:0] digital_pll_off, calibration_hold;
  int n_errors = 0;
  int check_count = 0;
  reg_data_t wval [9] = '{8'h5A, 8'h09, 8'h15, 8'h0E, 8'h01, 8'h0A, 8'h02,
    8'hA5, 8'h0B};
  wire [7:0] pump_view = {pump_current_sel, filter_series_res_sel,
    filter_parallel_cap_sel, second_pole_sel};
  wire [7:0] mode_view = {4'h0, synth_only_mode, lock_count_accuracy,
    manual_lock_override, manual_vco_choice};
  wire [7:0] pd_view = {xtal_doubler_off, input_ref_off, analog_pll_off,
    digital_pll_off};
  wire [7:0] lock_view = {2'h0, manual_lock_active, applied_lock_value};
  always #5 clk = ~clk;
  pll_b_cfg_regs DUT (
    .clk, .rst, .wr_en, .rd_en, .addr, .wdata, .rdata, .rd_valid, .hit,
    .pump_current_sel, .filter_series_res_sel, .filter_parallel_cap_sel,
    .second_pole_sel, .lock_count_accuracy, .manual_lock_override,
    .manual_vco_choice, .manual_lock_value_first_vco,
    .manual_lock_value_second_vco, .synth_only_mode, .manual_lock_active,
    .applied_lock_value, .xtal_doubler_off, .input_ref_off, .analog_pll_off,
    .output_off, .output_driver_hiz, .digital_pll_off, .calibration_hold
  );
  task automatic chk(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input reg_addr_t a, input reg_data_t exp);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("rdata", exp, rdata);
  endtask : rd
  task automatic t_reset_values;
    chk("pump", 8'h8B, pump_view);
    chk("mode", 8'h05, mode_view);
    chk("v1", 8'h0B, {3'h0, manual_lock_value_first_vco});
    chk("v2", 8'h00, {3'h0, manual_lock_value_second_vco});
    chk("pd", 8'h00, pd_view);
    chk("cal", 8'h00, {6'h00, calibration_hold});
    chk("out", 8'h00, output_off);
    rd(16'h00B0, 8'h8B);
    rd(16'h00B1, 8'h02);
    rd(16'h00B2, 8'h2B);
    for (int i = 3; i < 9; i++) rd(16'h00B0 + 16'(i), 8'h00);
  endtask : t_reset_values
  task automatic t_field_map;
    // Synth mode set here; free-run forcing lives outside
    for (int i = 0; i < 9; i++) wr(16'h00B0 + 16'(i), wval[i]);
    chk("pump", 8'h5A, pump_view);
    chk("mode", 8'h0A, mode_view);
    chk("lock", 8'h2E, lock_view);
    chk("pd", 8'hD6, pd_view);
    chk("cal", 8'h03, {6'h00, calibration_hold});
    chk("out", 8'hA5, output_off);
    chk("hiz", 8'hA5, output_driver_hiz);
    for (int i = 0; i < 9; i++) rd(16'h00B0 + 16'(i), wval[i]);
    wr(16'h00B2, 8'h35);
    chk("lock", 8'h35, lock_view);
    wr(16'h00B1, 8'h02);
    chk("lock", 8'h00, lock_view);
  endtask : t_field_map
  task automatic t_unmapped;
    wr(16'h00B9, 8'hFF);
    rd(16'h00B9, 8'h00);
    chk("hit", 8'h00, {7'h00, hit});
    rd(16'h00AF, 8'h00);
    rd(16'h00B8, 8'h0B);
    chk("hit", 8'h01, {7'h00, hit});
  endtask : t_unmapped
  task automatic t_mid_reset;
    wr(16'h00B7, 8'h3C);
    chk("out", 8'h3C, output_off);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset_values();
  endtask : t_mid_reset
  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    @(negedge clk);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset_values();
    t_field_map();
    t_unmapped();
    t_mid_reset();
    summarize();
  end
  // Whole run needs about 100 cycles; this cuts a hang
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule : pll_b_cfg_regs_test
